/* nav_out_cfg.svh */
`ifndef NAV_OUT_CFG_SVH
`define NAV_OUT_CFG_SVH
`define CLK_FREQ_HZ      100000000
`define EPOCH_CYCLES     100000000
`define BAUD_RATE        9600
`define BIT_CYCLES       (`CLK_FREQ_HZ / `BAUD_RATE)
`define MARK_TIME_US     500
`define MARK_CYCLES      ((`MARK_TIME_US * (`CLK_FREQ_HZ / 1000000)))
`define IDLE_GAP_MS      300
`define IDLE_GAP_CYCLES  (`IDLE_GAP_MS * (`CLK_FREQ_HZ / 1000))
`define MSG_LEN          16
`define FIFO_DEPTH       16
`define FIFO_WIDTH       8
`endif

/* nav_out_pkg.sv */
package nav_out_pkg;
  typedef enum logic [1:0] {FIX_NONE, FIX_TRACK, FIX_VALID} fix_mode_t;
  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} tx_state_t;
endpackage

/* byte_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic [WIDTH-1:0]      outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_reg;
  logic [AW-1:0]    rdPtr_reg;
  logic [AW:0]      count_reg;
  logic [AW-1:0]    wrPtr_next;
  logic [AW-1:0]    rdPtr_next;
  logic [AW:0]      count_next;
  logic             doWr;
  logic             doRd;
  assign inReady  = (count_reg != (AW+1)'(DEPTH));
  assign outValid = (count_reg != '0);
  assign outData  = mem[rdPtr_reg];
  always_comb begin
    doWr = inValid && inReady;
    doRd = outValid && outReady;
    wrPtr_next = doWr ? AW'(wrPtr_reg + 1'b1) : wrPtr_reg;
    rdPtr_next = doRd ? AW'(rdPtr_reg + 1'b1) : rdPtr_reg;
    count_next = count_reg;
    if (doWr && !doRd) begin
      count_next = (AW+1)'(count_reg + 1'b1);
    end else if (doRd && !doWr) begin
      count_next = (AW+1)'(count_reg - 1'b1);
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end else begin
      wrPtr_reg <= wrPtr_next;
      rdPtr_reg <= rdPtr_next;
      count_reg <= count_next;
    end
  end
  always_ff @(posedge clk) begin
    if (doWr) begin
      mem[wrPtr_reg] <= inData;
    end
  end
  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  property p_noOverflow;
    @(posedge clk) disable iff (!rstn) count_reg <= (AW+1)'(DEPTH);
  endproperty
  a_noOverflow: assert property (p_noOverflow) else $error("FIFO overflow.");
endmodule // byte_fifo
`default_nettype wire

/* gnss_status_and_serial_outputs.sv */
`timescale 1ns/1ps
`default_nettype none
`include "nav_out_cfg.svh"
// Overview of operation
// - Serial transmit line sits high whenever no character is sent.
// - One full sentence burst is sent every second.
// - Line stays idle high at least 300 ms before the next burst.
// - Serial receive input is ignored entirely.
// - Time mark pulses high about 500 us once per second.
// - Time mark rising edge follows the position epoch by one clock.
// - Fix status held low while nothing is tracked and navValid is low.
// - Tracking without fix blinks status 1000 ms high, 1000 ms low.
// - Valid fix holds the status output high.
// - Transmit framing is 9600 bit/s, 8 data bits, no parity, 1 stop.
// - Active low reset forces a cold start of all state.
module gnss_status_and_serial_outputs #(
  parameter int EPOCH_CYCLES = `EPOCH_CYCLES,
  parameter int BIT_CYCLES   = `BIT_CYCLES,
  parameter int MARK_CYCLES  = `MARK_CYCLES
) (
  input  wire logic       core_clk,
  input  wire logic       rstn,
  input  wire logic       serialIn,
  input  wire logic       satTracked,
  input  wire logic       navValid,
  output logic            serialOut,
  output logic            timeMark,
  output logic            fix_status_out
);
  // --------------------------------------------------------------------------
  // Reset release
  // --------------------------------------------------------------------------
  logic [1:0] rstSync_reg;
  logic       rstnInt;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rstSync_reg <= 2'h0;
    end else begin
      rstSync_reg <= {rstSync_reg[0], 1'b1};
    end
  end
  assign rstnInt = rstSync_reg[1];
  // --------------------------------------------------------------------------
  // Epoch, mark and status
  // --------------------------------------------------------------------------
  logic [31:0] epochCnt_reg, epochCnt_next;
  logic        epochTick;
  logic        mark_reg, mark_next;
  logic        blink_reg, blink_next;
  logic        fix_reg, fix_next;
  nav_out_pkg::fix_mode_t mode;
  always_comb begin
    epochTick = (epochCnt_reg == 32'(EPOCH_CYCLES - 1));
    epochCnt_next = epochTick ? 32'h0 : epochCnt_reg + 32'h1;
    mark_next = (epochCnt_reg < 32'(MARK_CYCLES));
    if (navValid) begin
      mode = nav_out_pkg::FIX_VALID;
    end else if (satTracked) begin
      mode = nav_out_pkg::FIX_TRACK;
    end else begin
      mode = nav_out_pkg::FIX_NONE;
    end
    blink_next = blink_reg;
    fix_next = fix_reg;
    if (epochTick) begin
      blink_next = ~blink_reg;
      unique case (mode)
        nav_out_pkg::FIX_NONE:  fix_next = 1'b0;
        nav_out_pkg::FIX_TRACK: fix_next = ~blink_reg;
        nav_out_pkg::FIX_VALID: fix_next = 1'b1;
      endcase
    end
  end
  always_ff @(posedge core_clk or negedge rstnInt) begin
    if (!rstnInt) begin
      epochCnt_reg <= 32'h0;
      mark_reg <= 1'b0;
      blink_reg <= 1'b0;
      fix_reg <= 1'b0;
    end else begin
      epochCnt_reg <= epochCnt_next;
      mark_reg <= mark_next;
      blink_reg <= blink_next;
      fix_reg <= fix_next;
    end
  end
  assign timeMark = mark_reg;
  assign fix_status_out = fix_reg;
  // --------------------------------------------------------------------------
  // Sentence source
  // --------------------------------------------------------------------------
  // The burst is short so the idle gap before the next epoch far exceeds
  // the required minimum; a longer message would need checking here.
  logic [4:0] msgIdx_reg, msgIdx_next;
  logic       msgBusy_reg, msgBusy_next;
  logic [7:0] msgByte;
  logic       fifoInReady;
  logic [7:0] fifoData;
  logic       fifoValid;
  logic       fifoReady;
  function automatic logic [7:0] hexDigit(input logic [3:0] v);
    hexDigit = (v < 4'hA) ? 8'(8'h30 + v) : 8'(8'h37 + v);
  endfunction
  always_comb begin
    unique case (msgIdx_reg)
      5'h00: msgByte = 8'h24;
      5'h01: msgByte = 8'h53;
      5'h02: msgByte = 8'h54;
      5'h03: msgByte = 8'h41;
      5'h04: msgByte = 8'h2C;
      5'h05: msgByte = hexDigit({2'h0, navValid, satTracked});
      5'h06: msgByte = 8'h2C;
      5'h07: msgByte = hexDigit({3'h0, fix_reg});
      5'h08: msgByte = 8'h2C;
      5'h09: msgByte = hexDigit({3'h0, blink_reg});
      5'h0A: msgByte = 8'h2A;
      5'h0B: msgByte = 8'h30;
      5'h0C: msgByte = 8'h30;
      5'h0D: msgByte = 8'h0D;
      default: msgByte = 8'h0A;
    endcase
    msgIdx_next = msgIdx_reg;
    msgBusy_next = msgBusy_reg;
    if (epochTick) begin
      msgBusy_next = 1'b1;
      msgIdx_next = 5'h00;
    end else if (msgBusy_reg && fifoInReady) begin
      if (msgIdx_reg == 5'(`MSG_LEN - 1)) begin
        msgBusy_next = 1'b0;
      end
      msgIdx_next = 5'(msgIdx_reg + 5'h1);
    end
  end
  always_ff @(posedge core_clk or negedge rstnInt) begin
    if (!rstnInt) begin
      msgIdx_reg <= 5'h00;
      msgBusy_reg <= 1'b0;
    end else begin
      msgIdx_reg <= msgIdx_next;
      msgBusy_reg <= msgBusy_next;
    end
  end
  byte_fifo #(
    .WIDTH(`FIFO_WIDTH),
    .DEPTH(`FIFO_DEPTH)
  ) u_fifo (
    .clk      (core_clk),
    .rstn     (rstnInt),
    .inData   (msgByte),
    .inValid  (msgBusy_reg && !epochTick),
    .inReady  (fifoInReady),
    .outData  (fifoData),
    .outValid (fifoValid),
    .outReady (fifoReady)
  );
  // --------------------------------------------------------------------------
  // Serial transmitter
  // --------------------------------------------------------------------------
  nav_out_pkg::tx_state_t txState_reg, txState_next;
  logic [15:0] bitCnt_reg, bitCnt_next;
  logic [2:0]  bitIdx_reg, bitIdx_next;
  logic [7:0]  shift_reg, shift_next;
  logic        txLine_reg, txLine_next;
  logic        bitEnd;
  always_comb begin
    bitEnd = (bitCnt_reg == 16'(BIT_CYCLES - 1));
    bitCnt_next = bitEnd ? 16'h0 : 16'(bitCnt_reg + 16'h1);
    txState_next = txState_reg;
    bitIdx_next = bitIdx_reg;
    shift_next = shift_reg;
    txLine_next = 1'b1;
    fifoReady = 1'b0;
    unique case (txState_reg)
      nav_out_pkg::TX_IDLE: begin
        bitCnt_next = 16'h0;
        if (fifoValid) begin
          fifoReady = 1'b1;
          shift_next = fifoData;
          txState_next = nav_out_pkg::TX_START;
          txLine_next = 1'b0;
        end
      end
      nav_out_pkg::TX_START: begin
        txLine_next = 1'b0;
        if (bitEnd) begin
          txState_next = nav_out_pkg::TX_DATA;
          bitIdx_next = 3'h0;
          txLine_next = shift_reg[0];
        end
      end
      nav_out_pkg::TX_DATA: begin
        txLine_next = shift_reg[bitIdx_reg];
        if (bitEnd) begin
          if (bitIdx_reg == 3'h7) begin
            txState_next = nav_out_pkg::TX_STOP;
            txLine_next = 1'b1;
          end else begin
            bitIdx_next = 3'(bitIdx_reg + 3'h1);
            txLine_next = shift_reg[bitIdx_next];
          end
        end
      end
      nav_out_pkg::TX_STOP: begin
        txLine_next = 1'b1;
        if (bitEnd) begin
          txState_next = nav_out_pkg::TX_IDLE;
        end
      end
    endcase
  end
  always_ff @(posedge core_clk or negedge rstnInt) begin
    if (!rstnInt) begin
      txState_reg <= nav_out_pkg::TX_IDLE;
      bitCnt_reg <= 16'h0;
      bitIdx_reg <= 3'h0;
      shift_reg <= 8'h00;
      txLine_reg <= 1'b1;
    end else begin
      txState_reg <= txState_next;
      bitCnt_reg <= bitCnt_next;
      bitIdx_reg <= bitIdx_next;
      shift_reg <= shift_next;
      txLine_reg <= txLine_next;
    end
  end
  assign serialOut = txLine_reg;
  // The receive pin is deliberately left unread by any logic.
  logic unusedRx;
  assign unusedRx = serialIn;
  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  property p_idleHigh;
    @(posedge core_clk) disable iff (!rstnInt)
      (txState_reg == nav_out_pkg::TX_IDLE && !fifoValid) |=> serialOut;
  endproperty
  a_idleHigh: assert property (p_idleHigh) else $error("Idle not high.");
  property p_markRise;
    @(posedge core_clk) disable iff (!rstnInt)
      $rose(timeMark) |-> epochCnt_reg == 32'h1;
  endproperty
  a_markRise: assert property (p_markRise) else $error("Mark off epoch.");
  property p_burstStart;
    @(posedge core_clk) disable iff (!rstnInt)
      epochTick |=> msgBusy_reg && msgIdx_reg == 5'h00;
  endproperty
  a_burstStart: assert property (p_burstStart) else $error("No burst.");
  property p_fixStable;
    @(posedge core_clk) disable iff (!rstnInt)
      !$past(epochTick) |-> $stable(fix_status_out);
  endproperty
  a_fixStable: assert property (p_fixStable) else $error("Fix moved.");
  property p_noTrack;
    @(posedge core_clk) disable iff (!rstnInt)
      (epochTick && !satTracked && !navValid) |=> !fix_status_out;
  endproperty
  a_noTrack: assert property (p_noTrack) else $error("Fix not low.");
  property p_valid;
    @(posedge core_clk) disable iff (!rstnInt)
      (epochTick && navValid) |=> fix_status_out;
  endproperty
  a_valid: assert property (p_valid) else $error("Fix not high.");
  property p_blink;
    @(posedge core_clk) disable iff (!rstnInt)
      (epochTick && satTracked && !navValid) |=> fix_status_out == blink_reg;
  endproperty
  a_blink: assert property (p_blink) else $error("Blink wrong.");
  // Falls inside a character are data bits; only a fall from idle or stop
  // must be a start bit.
  property p_startBit;
    @(posedge core_clk) disable iff (!rstnInt)
      ($fell(serialOut) && $past(txState_reg) != nav_out_pkg::TX_DATA) |->
        txState_reg == nav_out_pkg::TX_START;
  endproperty
  a_startBit: assert property (p_startBit) else $error("Bad frame.");
  c_burst: cover property (@(posedge core_clk) epochTick);
  c_mark: cover property (@(posedge core_clk) $fell(timeMark));
  c_stop: cover property (@(posedge core_clk)
    txState_reg == nav_out_pkg::TX_STOP && bitEnd);
endmodule // gnss_status_and_serial_outputs
`default_nettype wire

/* host_uart.sv */
`timescale 1ns/1ps
`default_nettype none
module host_uart #(
  parameter int BIT_CYCLES = 10
) (
  input  wire logic       clk,
  input  wire logic       rxLine,
  input  wire logic       txEnable,
  output logic            txLine,
  output logic [7:0]      rxByte,
  output logic            rxFrameErr,
  output int              rxCount
);
  // ----------------------------------------------------------------
  // Receiver and chatter transmitter
  // ----------------------------------------------------------------
  // Start bit, A5 sent LSB first, stop bit.
  localparam logic [9:0] TX_FRAME = 10'h34A;
  int txCnt;
  initial begin
    txLine     = 1'b1;
    txCnt      = 0;
    rxByte     = 8'h00;
    rxFrameErr = 1'b0;
    rxCount    = 0;
  end
  // The host keeps talking although the device must not listen.
  always @(posedge clk) begin
    txCnt  <= (txCnt == BIT_CYCLES * 10 - 1) ? 0 : txCnt + 1;
    txLine <= txEnable ? TX_FRAME[txCnt / BIT_CYCLES] : 1'b1;
  end
  // Mid-bit sampling at 8N1 tolerates a skew of half a bit.
  always begin
    @(negedge rxLine);
    repeat (BIT_CYCLES / 2) @(posedge clk);
    if (rxLine === 1'b0) begin
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYCLES) @(posedge clk);
        rxByte[i] = rxLine;
      end
      repeat (BIT_CYCLES) @(posedge clk);
      rxFrameErr = (rxLine !== 1'b1);
      rxCount    = rxCount + 1;
    end
  end
endmodule // host_uart
`default_nettype wire

/* test_gnss_status_and_serial_outputs.sv */
`timescale 1ns/1ps
`default_nettype none
module test_gnss_status_and_serial_outputs;
  localparam int EPOCH = 5000;
  localparam int BITC  = 10;
  localparam int MARKC = 5;
  logic       core_clk   = 1'b0;
  logic       rstn       = 1'b0;
  logic       satTracked = 1'b0;
  logic       navValid   = 1'b0;
  logic       txEnable   = 1'b1;
  logic       serialIn;
  logic       serialOut;
  logic       timeMark;
  logic       fixOut;
  logic [7:0] rxByte;
  logic       rxFrameErr;
  int         rxCount;
  int         fail_count = 0;
  int         cmp_count  = 0;
  int         cycles     = 0;
  int         sinceMark  = 0;
  int         sinceLow   = 0;
  int         markLen    = 0;
  logic       prevMark   = 1'b0;
  logic       prevFix    = 1'b0;
  logic       seenMark   = 1'b0;
  logic [7:0] q[$];

  always #5 core_clk = ~core_clk;

  gnss_status_and_serial_outputs #(
    .EPOCH_CYCLES(EPOCH), .BIT_CYCLES(BITC), .MARK_CYCLES(MARKC)
  ) uut (
    .core_clk(core_clk), .rstn(rstn), .serialIn(serialIn),
    .satTracked(satTracked), .navValid(navValid),
    .serialOut(serialOut), .timeMark(timeMark), .fix_status_out(fixOut)
  );

  host_uart #(.BIT_CYCLES(BITC)) host (
    .clk(core_clk), .rxLine(serialOut), .txEnable(txEnable),
    .txLine(serialIn), .rxByte(rxByte), .rxFrameErr(rxFrameErr),
    .rxCount(rxCount)
  );

  always @(rxCount) q.push_back(rxByte);

  // ----------------------------------------------------------------
  // Checking helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                       input string what);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s seen %h expected %h",
               $time, what, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 80000) begin
      fail_count++;
      $display("unexpected at %0t: run took too long", $time);
      close_out();
    end
  end

  // Timing watch on the outputs, sampled at the falling edge.
  always @(negedge core_clk) begin
    if (!rstn) begin
      sinceMark = 0;
      sinceLow  = 0;
      seenMark  = 1'b0;
    end else begin
      sinceMark++;
      sinceLow = (serialOut === 1'b0) ? 0 : sinceLow + 1;
      if (timeMark && !prevMark) begin
        if (seenMark) begin
          check(8'(sinceMark == EPOCH), 8'h01, "epoch spacing");
          check(8'(sinceLow >= EPOCH * 3 / 10), 8'h01, "idle gap");
        end
        seenMark  = 1'b1;
        sinceMark = 0;
      end else if (sinceMark != EPOCH - 1)
        // The status register updates at the epoch wrap, one cycle before
        // the mark rises, so that single cycle is exempt.
        check(8'(fixOut), 8'(prevFix), "fix changed mid-epoch");
      if (!timeMark && prevMark)
        check(8'(markLen == MARKC && sinceMark == MARKC), 8'h01,
              "time mark width");
      markLen = timeMark ? markLen + 1 : 0;
    end
    prevMark = timeMark;
    prevFix  = fixOut;
  end

  task automatic wait_mark();
    int n;
    n = 0;
    while (timeMark !== 1'b0) @(negedge core_clk);
    while (timeMark !== 1'b1 && n < EPOCH + 20) begin
      @(negedge core_clk);
      n++;
    end
    check(8'(timeMark), 8'h01, "no time mark");
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_levels();
    @(negedge core_clk);
    check(8'(serialOut), 8'h01, "line not idle in reset");
    check(8'(timeMark), 8'h00, "mark in reset");
    check(8'(fixOut), 8'h00, "fix in reset");
    $display("test reset levels done");
  endtask

  // Inputs are applied for a whole epoch before the burst that reports
  // them, so the mode digit and the status both reflect them.
  task automatic t_mode(input logic s, input logic v);
    logic fA;
    logic fB;
    wait_mark();
    @(posedge core_clk);
    satTracked <= s;
    navValid   <= v;
    wait_mark();
    fA = fixOut;
    q.delete();
    wait_mark();
    fB = fixOut;
    check(8'(q.size()), 8'h10, "burst length");
    check(q.size() > 0 ? q[0] : 8'h00, 8'h24, "sentence start");
    check(q.size() > 5 ? q[5] : 8'h00, 8'h30 + 8'({v, s}), "mode digit");
    check(8'(rxFrameErr), 8'h00, "framing");
    if (v)
      check(8'(fA & fB), 8'h01, "fix high");
    else if (s)
      check(8'(fA ^ fB), 8'h01, "blink");
    else
      check(8'(fA | fB), 8'h00, "fix low");
    $display("test mode %b%b done", v, s);
  endtask

  task automatic t_cold_start();
    repeat (EPOCH / 3) @(posedge core_clk);
    rstn <= 1'b0;
    satTracked <= 1'b0;
    navValid   <= 1'b0;
    @(posedge core_clk);
    @(negedge core_clk);
    check(8'(fixOut), 8'h00, "fix after cold start");
    check(8'(timeMark), 8'h00, "mark after cold start");
    check(8'(serialOut), 8'h01, "line after cold start");
    @(posedge core_clk);
    rstn <= 1'b1;
    $display("test cold start done");
  endtask

  initial begin
    repeat (2) @(posedge core_clk);
    t_reset_levels();
    @(posedge core_clk);
    rstn <= 1'b1;
    t_mode(1'b1, 1'b0);
    t_mode(1'b1, 1'b1);
    t_cold_start();
    t_mode(1'b0, 1'b0);
    close_out();
  end
endmodule // test_gnss_status_and_serial_outputs
`default_nettype wire
